// ### testbench/psg_ee_model.sv
// Behavioural serial memory that stores save frames and answers restore frames.
`timescale 1ns/1ps
module psg_ee_model (
    input  wire logic sclk_in,
    input  wire logic cs_n_in,
    input  wire logic mosi_in,
    output logic      miso_out
);
    logic [31:0] w [8];
    logic [7:0]  cmd;
    int          n;
    initial miso_out = 1'b0;
    initial foreach (w[i]) w[i] = 32'h0;
    always @(negedge cs_n_in) n = 0;
    // A released data line shows the inverse of its last level, never a stale bit.
    always @(posedge cs_n_in) miso_out = ~miso_out;
    always @(posedge sclk_in)
    begin
        if (!cs_n_in)
        begin
            if (n < 8)
                cmd = {cmd[6:0], mosi_in};
            else if (n >= 24 && n < 280 && cmd == 8'h02)
                w[(n - 24) / 32] = {w[(n - 24) / 32][30:0], mosi_in};
            n = n + 1;
        end
    end
    always @(negedge sclk_in)
    begin
        if (!cs_n_in && n >= 24 && n < 280 && cmd == 8'h03)
            miso_out = w[(n - 24) / 32][31 - (n - 24) % 32];
        else if (!cs_n_in)
            miso_out = ~miso_out;
    end
endmodule

// ### testbench/psg_regs_bench.sv
// Self-checking bench of the parameter-save register bank.
`timescale 1ns/1ps
module psg_regs_bench;
    import psg_pkg::*;
    logic         mclk_in = 1'b0, rst_n_in = 1'b0, cp_wr_in = 1'b0, cp_rd_in = 1'b0;
    logic         hw = 1'b0, aw = 1'b0, sample_tick_in = 1'b0, aux_valid_in = 1'b0;
    logic         save_trig_in = 1'b0, save_trig_rising_in = 1'b0, self_boot_in = 1'b0;
    logic [11:0]  cp_addr_in = 12'h000, aux_filt_in = 12'h000, pin_level_bits_out;
    logic [31:0]  cp_wdata_in = 32'h0, cp_rdata_out;
    logic [223:0] param_core_in = 224'h0;
    logic [1:0]   aux_chan_in = 2'h0, aux_conv_filter_sel_out, out_conv_setup_out;
    logic [7:0]   aux_code_in = 8'h00;
    logic [111:0] aux_param_out;
    logic [3:0]   out_conv_powerdown_out;
    logic         cp_rvalid_out, ee_sclk_out, ee_cs_n_out, ee_mosi_out, ee_miso_in;
    logic         ee_busy_out, aux_conv_powerdown_out, ref_buffer_powerdown_out;
    logic         ref_powerdown_out, aux_conv_on_out, osc_off_out;
    logic [31:0]  m [12'h800:12'h830];
    int           failures = 0, cmp_count = 0, cyc = 0, v;
    psg_regs dut (.saved_param_host_write_in(hw), .aux_data_host_write_in(aw), .*);
    psg_ee_model ee (.sclk_in(ee_sclk_out), .cs_n_in(ee_cs_n_out), .mosi_in(ee_mosi_out),
                     .miso_out(ee_miso_in));
    always #10 mclk_in = ~mclk_in;
    always @(posedge mclk_in)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            failures++;
            summarize();
        end
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h seen %h", s, exp, seen);
        end
    endtask
    function automatic logic [31:0] mk(input int a);
        if (a <= 12'h807) return 32'h0fffffff;
        if (a <= 12'h80c) return 32'h00000fff;
        if (a == 12'h820 || a == 12'h821) return 32'h00ffffff;
        if (a == 12'h822) return 32'h000003ef;
        if (a == 12'h824) return 32'h00008000;
        if (a == 12'h826) return 32'h00000004;
        if (a == 12'h827) return 32'h00000003;
        return 32'h0;
    endfunction
    task automatic wr(input int a, input logic [31:0] x);
        @(posedge mclk_in);
        cp_addr_in <= 12'(a);
        cp_wdata_in <= x;
        cp_wr_in <= 1'b1;
        @(posedge mclk_in);
        cp_wr_in <= 1'b0;
        if (!((a <= 12'h807 && !hw) || (a >= 12'h809 && a <= 12'h80c && !aw)))
            m[a] = x;
    endtask
    task automatic rd(input int a);
        @(posedge mclk_in);
        cp_addr_in <= 12'(a);
        cp_rd_in <= 1'b1;
        @(posedge mclk_in);
        cp_rd_in <= 1'b0;
        @(negedge mclk_in);
        chk("rvalid", {31'h0, cp_rvalid_out}, 32'h1);
        chk($sformatf("reg %h", a), cp_rdata_out, m[a] & mk(a));
    endtask
    task automatic rdall(input int lo, input int hi);
        for (int a = lo; a <= hi; a++) rd(a);
    endtask
    task automatic outs();
        logic [11:0] p;
        logic [31:0] r;
        r = m[12'h822];
        for (int i = 0; i < 12; i++)
            p[i] = 4'(m[i < 6 ? 12'h820 : 12'h821] >> (4 * (i % 6))) == 4'h1 && m[12'h808][i];
        chk("pins", {20'h0, pin_level_bits_out}, {20'h0, p});
        chk("pwr", {aux_conv_filter_sel_out, aux_conv_powerdown_out, ref_buffer_powerdown_out,
            ref_powerdown_out, out_conv_powerdown_out}, {r[9:5], r[0], r[1], r[2], r[3]});
        chk("misc", {aux_conv_on_out, osc_off_out, out_conv_setup_out},
            {m[12'h824][15], m[12'h826][2], m[12'h827][1:0]});
    endtask
    task automatic rst(input logic b);
        @(posedge mclk_in);
        self_boot_in <= b;
        rst_n_in <= 1'b0;
        repeat (10) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        for (int a = 12'h800; a <= 12'h830; a++) if (a > 12'h807 || !b) m[a] = 32'h0;
    endtask
    task automatic tick();
        @(posedge mclk_in);
        param_core_in <= {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
        sample_tick_in <= 1'b1;
        @(posedge mclk_in);
        sample_tick_in <= 1'b0;
        for (int i = 0; i < 8; i++) if (!hw) m[12'h800 + i] = {4'h0, param_core_in[28 * i +: 28]};
        rdall(12'h800, 12'h807);
    endtask
    task automatic aux(input int c);
        @(posedge mclk_in);
        aux_chan_in <= 2'(c);
        aux_code_in <= (c == 0) ? 8'hff : 8'($urandom);
        aux_filt_in <= 12'($urandom);
        aux_valid_in <= 1'b1;
        @(posedge mclk_in);
        aux_valid_in <= 1'b0;
        if (m[12'h822][9:8] == 2'h0)
            v = (aux_code_in * 32'h808 + 32'h80) >> 8;
        else
            v = (aux_filt_in * 32'h801) >> 12;
        m[12'h809 + c] = v;
        repeat (2) @(posedge mclk_in);
        @(negedge mclk_in);
        chk("aux", {4'h0, aux_param_out[28 * c +: 28]}, {8'h0, v[11:0], 12'h0});
        rd(12'h809 + c);
    endtask
    task automatic wt(input logic b, input int lim);
        int n;
        n = 0;
        while (ee_busy_out !== b && n < lim)
        begin
            @(negedge mclk_in);
            n++;
        end
        chk("busy", {31'h0, ee_busy_out}, {31'h0, b});
    endtask
    task automatic save(input logic t);
        @(posedge mclk_in);
        save_trig_in <= t;
        wt(1'b1, 20);
        wt(1'b0, 16000);
        for (int i = 0; i < 8; i++) chk("stored", ee.w[i], m[12'h800 + i] & 32'h0fffffff);
    endtask
    initial
    begin
        v = $urandom(59);
        rst(1'b0);
        chk("cs_n", {31'h0, ee_cs_n_out}, 32'h1);
        rdall(12'h800, 12'h830);
        $display("test reset done");
        @(posedge mclk_in);
        hw <= 1'b1;
        aw <= 1'b1;
        for (int a = 12'h800; a <= 12'h830; a++) wr(a, $urandom);
        wr(12'h820, 32'h00011001);
        wr(12'h821, 32'h00100110);
        rdall(12'h800, 12'h830);
        outs();
        $display("test host write done");
        @(posedge mclk_in);
        hw <= 1'b0;
        aw <= 1'b0;
        wr(12'h800, $urandom);
        wr(12'h80a, $urandom);
        rdall(12'h800, 12'h80c);
        tick();
        @(posedge mclk_in);
        hw <= 1'b1;
        tick();
        $display("test core refresh done");
        wr(12'h824, 32'h00008000);
        for (int s = 0; s < 4; s++)
        begin
            wr(12'h822, s << 8);
            for (int c = 0; c < 4; c++) aux(c);
        end
        $display("test aux data done");
        @(posedge mclk_in);
        save_trig_in <= 1'b1;
        repeat (20) @(posedge mclk_in);
        chk("busy", {31'h0, ee_busy_out}, 32'h0);
        save(1'b0);
        wr(12'h801, $urandom);
        save_trig_rising_in <= 1'b1;
        save(1'b1);
        $display("test save done");
        rst(1'b1);
        wt(1'b1, 20);
        wt(1'b0, 16000);
        rdall(12'h800, 12'h830);
        chk("busy", {31'h0, ee_busy_out}, 32'h0);
        outs();
        $display("test restore done");
        summarize();
    end
endmodule

// ### verilog/psg_defs.svh
// Offsets, field positions, reset values and timing counts of the parameter-save register bank.
// Function
// - Eight 32-bit registers, 28-bit zero-padded parameters
// - Core refreshes saved parameters every sample outside memory frames
// - Selected trigger edge saves registers to memory
// - Self-boot reset restores parameters from memory
// - Host write mode: host writes, core stops
// - Parameter bits 27:0, bits 31:28 zero
// - Twelve pin levels in 11:0, rest zero
// - Four auxiliary data registers, one per channel
// - Eight-bit results, twelve when filtering selected
// - Core sees auxiliary data as 5.23 word
// - Four-bit pin fields, two 24-bit registers
// - Filter, converter, reference, output power-down bits
// - Unfilled bit positions have no function
// - Host may write auxiliary data when enabled
// - Code 255 maps to 1.0 in 5.23
`ifndef PSG_DEFS_SVH
`define PSG_DEFS_SVH

`define PSG_PARAM0_ADDR    12'h800
`define PSG_PARAM7_ADDR    12'h807
`define PSG_PIN_LEVEL_ADDR 12'h808
`define PSG_AUX0_ADDR      12'h809
`define PSG_AUX3_ADDR      12'h80c
`define PSG_PCFG_LO_ADDR   12'h820
`define PSG_PCFG_HI_ADDR   12'h821
`define PSG_AUX_PWR_ADDR   12'h822
`define PSG_RSVD_A_ADDR    12'h823
`define PSG_AUX_EN_ADDR    12'h824
`define PSG_RSVD_B_ADDR    12'h825
`define PSG_OSC_PD_ADDR    12'h826
`define PSG_OUT_SETUP_ADDR 12'h827

`define PSG_AUX_PWR_MASK   16'h03ef
`define PSG_FIL_POS        8
`define PSG_AUX_CONV_POWERDOWN_POS       7
`define PSG_REF_BUFFER_POWERDOWN_POS       6
`define PSG_REF_POWERDOWN_POS       5
`define PSG_AUX_EN_POS     15
`define PSG_OSC_PD_POS     2
`define PSG_RST_16         16'h0000
`define PSG_RST_24         24'h000000
`define PSG_RST_28         28'h0000000

`define PSG_PIN_HOST_CODE  4'h1
`define PSG_EE_CMD_READ    8'h03
`define PSG_EE_CMD_WRITE   8'h02
`define PSG_EE_BASE        16'h0000
`define PSG_EE_HDR_BITS    9'd24
`define PSG_EE_LAST_BIT    9'd279

`define PSG_CLK_NS         20
`define PSG_EE_HALF_NS     500
`define PSG_EE_HALF_CYC    ((`PSG_EE_HALF_NS + `PSG_CLK_NS - 1) / `PSG_CLK_NS)

`endif

// ### verilog/psg_pkg.sv
// Types shared by the parameter-save register bank.
package psg_pkg;
    typedef enum logic [1:0] {
        PSG_EE_IDLE  = 2'b00,
        PSG_EE_READ  = 2'b01,
        PSG_EE_WRITE = 2'b10
    } psg_ee_state_t;
    typedef logic [27:0] psg_param_t;
    typedef logic [11:0] psg_aux_t;
endpackage

// ### verilog/psg_regs.sv
// Parameter-save, pin, auxiliary converter and power control register bank.
`timescale 1ns/1ps
`include "psg_defs.svh"
module psg_regs (
    input  wire logic         mclk_in,
    input  wire logic         rst_n_in,
    input  wire logic [11:0]  cp_addr_in,
    input  wire logic [31:0]  cp_wdata_in,
    input  wire logic         cp_wr_in,
    input  wire logic         cp_rd_in,
    output logic      [31:0]  cp_rdata_out,
    output logic              cp_rvalid_out,
    input  wire logic         saved_param_host_write_in,
    input  wire logic         aux_data_host_write_in,
    input  wire logic         sample_tick_in,
    input  wire logic [223:0] param_core_in,
    input  wire logic         aux_valid_in,
    input  wire logic [1:0]   aux_chan_in,
    input  wire logic [7:0]   aux_code_in,
    input  wire logic [11:0]  aux_filt_in,
    output logic      [111:0] aux_param_out,
    input  wire logic         save_trig_in,
    input  wire logic         save_trig_rising_in,
    input  wire logic         self_boot_in,
    output logic              ee_sclk_out,
    output logic              ee_cs_n_out,
    output logic              ee_mosi_out,
    input  wire logic         ee_miso_in,
    output logic              ee_busy_out,
    output logic      [11:0]  pin_level_bits_out,
    output logic      [1:0]   aux_conv_filter_sel_out,
    output logic              aux_conv_powerdown_out,
    output logic              ref_buffer_powerdown_out,
    output logic              ref_powerdown_out,
    output logic      [3:0]   out_conv_powerdown_out,
    output logic              aux_conv_on_out,
    output logic              osc_off_out,
    output logic      [1:0]   out_conv_setup_out
);
    import psg_pkg::*;

    localparam logic [7:0] EE_HALF = 8'(`PSG_EE_HALF_CYC - 1);

    psg_param_t    param_r [8];
    psg_param_t    param_nxt [8];
    psg_aux_t      aux_r [4];
    psg_aux_t      aux_nxt [4];
    logic [11:0]   pin_level_r, pin_level_nxt, mp_r, mp_nxt;
    logic [23:0]   pcfg_lo_r, pcfg_lo_nxt, pcfg_hi_r, pcfg_hi_nxt;
    logic [15:0]   aux_pwr_r, aux_pwr_nxt;
    logic          aux_en_r, aux_en_nxt, osc_pd_r, osc_pd_nxt;
    logic [1:0]    out_setup_r, out_setup_nxt;
    logic [31:0]   rdata_r, rdata_nxt;
    logic          rvalid_r, rvalid_nxt;
    logic [255:0]  param_flat;

    psg_ee_state_t state_r, state_nxt;
    logic [8:0]    bit_cnt_r, bit_cnt_nxt;
    logic [7:0]    div_r, div_nxt;
    logic          sclk_r, sclk_nxt, cs_n_r, cs_n_nxt, mosi_r, mosi_nxt;
    logic          boot_pend_r, boot_pend_nxt, save_pend_r, save_pend_nxt;
    logic          busy_r, busy_nxt;
    logic [1:0]    settle_r, settle_nxt;
    logic          trig_q1_r, trig_s_r, trig_prev_r, boot_q1_r, boot_s_r;
    logic          miso_q1_r, miso_s_r;
    logic          trig_edge, div_tick, rx_take, boot_go;
    logic [8:0]    rx_j;

    function automatic logic psg_tx_bit(input logic [8:0] cnt, input logic wr,
                                        input logic [255:0] flat);
        logic [8:0]  j;
        logic [7:0]  cmd;
        logic [15:0] base;
        j    = cnt - `PSG_EE_HDR_BITS;
        cmd  = wr ? `PSG_EE_CMD_WRITE : `PSG_EE_CMD_READ;
        base = `PSG_EE_BASE;
        if (cnt < 9'd8)
            psg_tx_bit = cmd[3'd7 - cnt[2:0]];
        else if (cnt < `PSG_EE_HDR_BITS)
            psg_tx_bit = base[4'd15 - 4'(cnt - 9'd8)];
        else
            psg_tx_bit = wr & flat[8'hff - j[7:0]];
    endfunction

    // 1.11 core word
    // Full scale lands on exactly 1.0 (0x800), not 0xff0, so the core sees the top code as unity.
    function automatic psg_aux_t psg_aux_scale(input logic [1:0] fsel, input logic [7:0] c8,
                                               input logic [11:0] c12);
        logic [23:0] p;
        p = 24'h000000;
        if (fsel == 2'h0)
        begin
            p = ({16'h0000, c8} * 24'h000808) + 24'h000080;
            psg_aux_scale = p[19:8];
        end
        else
        begin
            p = {12'h000, c12} * 24'h000801;
            psg_aux_scale = p[23:12];
        end
    endfunction

    // synchronized trigger edge
    // Held off until the synchronizer has filled, so a pin resting high at reset is no edge.
    assign trig_edge = (settle_r == 2'h3)
                       && (save_trig_rising_in ? (trig_s_r & ~trig_prev_r)
                                               : (~trig_s_r & trig_prev_r));
    assign div_tick  = (div_r == 8'h00);
    assign rx_j      = bit_cnt_r - `PSG_EE_HDR_BITS;
    assign rx_take   = (state_r == PSG_EE_READ) && div_tick && !sclk_r
                       && (bit_cnt_r >= `PSG_EE_HDR_BITS);
    assign boot_go   = (state_r == PSG_EE_IDLE) && boot_pend_r && (settle_r == 2'h3);

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_flat
            assign param_flat[255 - 32*gi -: 32] = {4'h0, param_r[gi]};
        end
        for (gi = 0; gi < 4; gi++)
        begin : g_aux
            assign aux_param_out[28*gi +: 28] = {4'h0, aux_r[gi], 12'h000};
        end
    endgenerate

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            trig_q1_r   <= 1'b0;
            trig_s_r    <= 1'b0;
            trig_prev_r <= 1'b0;
            boot_q1_r   <= 1'b0;
            boot_s_r    <= 1'b0;
            miso_q1_r   <= 1'b0;
            miso_s_r    <= 1'b0;
        end
        else
        begin
            trig_q1_r   <= save_trig_in;
            trig_s_r    <= trig_q1_r;
            trig_prev_r <= trig_s_r;
            boot_q1_r   <= self_boot_in;
            boot_s_r    <= boot_q1_r;
            miso_q1_r   <= ee_miso_in;
            miso_s_r    <= miso_q1_r;
        end
    end

    // Memory engine: mode 0 serial frames, command, 16-bit address, then 256 data bits.
    always_comb
    begin
        state_nxt     = state_r;
        bit_cnt_nxt   = bit_cnt_r;
        div_nxt       = (div_r == 8'h00) ? EE_HALF : div_r - 8'h01;
        sclk_nxt      = sclk_r;
        cs_n_nxt      = cs_n_r;
        mosi_nxt      = mosi_r;
        boot_pend_nxt = boot_pend_r;
        save_pend_nxt = save_pend_r | trig_edge;
        settle_nxt    = (settle_r == 2'h3) ? settle_r : settle_r + 2'h1;
        case (state_r)
            PSG_EE_IDLE:
            begin
                div_nxt = EE_HALF;
                if (boot_go)
                begin
                    boot_pend_nxt = 1'b0;
                    if (boot_s_r)
                    begin
                        state_nxt   = PSG_EE_READ;
                        cs_n_nxt    = 1'b0;
                        bit_cnt_nxt = 9'd0;
                        mosi_nxt    = psg_tx_bit(9'd0, 1'b0, param_flat);
                    end
                end
                else if (!boot_pend_r && (save_pend_r || trig_edge))
                begin
                    // save on edge
                    // An edge landing as a pending save starts stays pending for one more frame.
                    save_pend_nxt = save_pend_r & trig_edge;
                    state_nxt     = PSG_EE_WRITE;
                    cs_n_nxt      = 1'b0;
                    bit_cnt_nxt   = 9'd0;
                    mosi_nxt      = psg_tx_bit(9'd0, 1'b1, param_flat);
                end
            end
            PSG_EE_READ, PSG_EE_WRITE:
            begin
                if (div_tick)
                begin
                    sclk_nxt = ~sclk_r;
                    if (sclk_r)
                    begin
                        if (bit_cnt_r == `PSG_EE_LAST_BIT)
                        begin
                            state_nxt = PSG_EE_IDLE;
                            cs_n_nxt  = 1'b1;
                            mosi_nxt  = 1'b0;
                        end
                        else
                        begin
                            bit_cnt_nxt = bit_cnt_r + 9'd1;
                            mosi_nxt    = psg_tx_bit(bit_cnt_r + 9'd1,
                                                     state_r == PSG_EE_WRITE, param_flat);
                        end
                    end
                end
            end
            default:
            begin
                state_nxt = PSG_EE_IDLE;
                cs_n_nxt  = 1'b1;
                sclk_nxt  = 1'b0;
            end
        endcase
        busy_nxt      = (state_nxt != PSG_EE_IDLE);
    end

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_r     <= PSG_EE_IDLE;
            busy_r      <= 1'b0;
            bit_cnt_r   <= 9'd0;
            div_r       <= 8'h00;
            sclk_r      <= 1'b0;
            cs_n_r      <= 1'b1;
            mosi_r      <= 1'b0;
            boot_pend_r <= 1'b1;
            save_pend_r <= 1'b0;
            settle_r    <= 2'h0;
        end
        else
        begin
            state_r     <= state_nxt;
            busy_r      <= busy_nxt;
            bit_cnt_r   <= bit_cnt_nxt;
            div_r       <= div_nxt;
            sclk_r      <= sclk_nxt;
            cs_n_r      <= cs_n_nxt;
            mosi_r      <= mosi_nxt;
            boot_pend_r <= boot_pend_nxt;
            save_pend_r <= save_pend_nxt;
            settle_r    <= settle_nxt;
        end
    end

    // Register file. Core refresh pauses while a frame runs so a save never mixes two samples.
    always_comb
    begin
        logic [11:0] aoff;
        logic [47:0] cfg_all;
        aoff          = cp_addr_in - `PSG_AUX0_ADDR;
        cfg_all       = {pcfg_hi_r, pcfg_lo_r};
        param_nxt     = param_r;
        aux_nxt       = aux_r;
        pin_level_nxt = pin_level_r;
        pcfg_lo_nxt   = pcfg_lo_r;
        pcfg_hi_nxt   = pcfg_hi_r;
        aux_pwr_nxt   = aux_pwr_r;
        aux_en_nxt    = aux_en_r;
        osc_pd_nxt    = osc_pd_r;
        out_setup_nxt = out_setup_r;
        rvalid_nxt    = cp_rd_in;
        rdata_nxt     = 32'h00000000;
        if (sample_tick_in && !saved_param_host_write_in && state_r == PSG_EE_IDLE)
            for (int i = 0; i < 8; i++)
                param_nxt[i] = param_core_in[28*i +: 28];
        if (rx_take && rx_j[4:0] > 5'd3)
            param_nxt[rx_j[7:5]][5'd31 - rx_j[4:0]] = miso_s_r;
        if (aux_valid_in && aux_en_r && !aux_pwr_r[`PSG_AUX_CONV_POWERDOWN_POS] && !aux_data_host_write_in)
            aux_nxt[aux_chan_in] = psg_aux_scale(aux_pwr_r[`PSG_FIL_POS +: 2],
                                                 aux_code_in, aux_filt_in);
        if (cp_wr_in)
        begin
            if (saved_param_host_write_in && cp_addr_in >= `PSG_PARAM0_ADDR
                && cp_addr_in <= `PSG_PARAM7_ADDR)
                param_nxt[cp_addr_in[2:0]] = cp_wdata_in[27:0];
            if (aux_data_host_write_in && cp_addr_in >= `PSG_AUX0_ADDR
                && cp_addr_in <= `PSG_AUX3_ADDR)
                aux_nxt[aoff[1:0]] = cp_wdata_in[11:0];
            case (cp_addr_in)
                `PSG_PIN_LEVEL_ADDR: pin_level_nxt = cp_wdata_in[11:0];
                `PSG_PCFG_LO_ADDR:   pcfg_lo_nxt   = cp_wdata_in[23:0];
                `PSG_PCFG_HI_ADDR:   pcfg_hi_nxt   = cp_wdata_in[23:0];
                `PSG_AUX_PWR_ADDR:   aux_pwr_nxt   = cp_wdata_in[15:0] & `PSG_AUX_PWR_MASK;
                `PSG_AUX_EN_ADDR:    aux_en_nxt    = cp_wdata_in[`PSG_AUX_EN_POS];
                `PSG_OSC_PD_ADDR:    osc_pd_nxt    = cp_wdata_in[`PSG_OSC_PD_POS];
                `PSG_OUT_SETUP_ADDR: out_setup_nxt = cp_wdata_in[1:0];
                default:             rdata_nxt     = 32'h00000000;
            endcase
        end
        if (cp_rd_in)
        begin
            if (cp_addr_in >= `PSG_PARAM0_ADDR && cp_addr_in <= `PSG_PARAM7_ADDR)
                rdata_nxt = {4'h0, param_r[cp_addr_in[2:0]]};
            else if (cp_addr_in >= `PSG_AUX0_ADDR && cp_addr_in <= `PSG_AUX3_ADDR)
                rdata_nxt = {20'h00000, aux_r[aoff[1:0]]};
            else
                case (cp_addr_in)
                    `PSG_PIN_LEVEL_ADDR: rdata_nxt = {20'h00000, pin_level_r};
                    `PSG_PCFG_LO_ADDR:   rdata_nxt = {8'h00, pcfg_lo_r};
                    `PSG_PCFG_HI_ADDR:   rdata_nxt = {8'h00, pcfg_hi_r};
                    `PSG_AUX_PWR_ADDR:   rdata_nxt = {16'h0000, aux_pwr_r};
                    `PSG_AUX_EN_ADDR:    rdata_nxt = {16'h0000, aux_en_r, 15'h0000};
                    `PSG_OSC_PD_ADDR:    rdata_nxt = {29'h00000000, osc_pd_r, 2'h0};
                    `PSG_OUT_SETUP_ADDR: rdata_nxt = {30'h00000000, out_setup_r};
                    default:             rdata_nxt = 32'h00000000;
                endcase
        end
        for (int i = 0; i < 12; i++)
            mp_nxt[i] = (cfg_all[4*i +: 4] == `PSG_PIN_HOST_CODE) & pin_level_r[i];
    end

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            for (int i = 0; i < 8; i++)
                param_r[i] <= `PSG_RST_28;
            for (int i = 0; i < 4; i++)
                aux_r[i] <= 12'h000;
            pin_level_r <= 12'h000;
            mp_r        <= 12'h000;
            pcfg_lo_r   <= `PSG_RST_24;
            pcfg_hi_r   <= `PSG_RST_24;
            aux_pwr_r   <= `PSG_RST_16;
            aux_en_r    <= 1'b0;
            osc_pd_r    <= 1'b0;
            out_setup_r <= 2'h0;
            rdata_r     <= 32'h00000000;
            rvalid_r    <= 1'b0;
        end
        else
        begin
            param_r     <= param_nxt;
            aux_r       <= aux_nxt;
            pin_level_r <= pin_level_nxt;
            mp_r        <= mp_nxt;
            pcfg_lo_r   <= pcfg_lo_nxt;
            pcfg_hi_r   <= pcfg_hi_nxt;
            aux_pwr_r   <= aux_pwr_nxt;
            aux_en_r    <= aux_en_nxt;
            osc_pd_r    <= osc_pd_nxt;
            out_setup_r <= out_setup_nxt;
            rdata_r     <= rdata_nxt;
            rvalid_r    <= rvalid_nxt;
        end
    end

    assign cp_rdata_out             = rdata_r;
    assign cp_rvalid_out            = rvalid_r;
    assign ee_sclk_out              = sclk_r;
    assign ee_cs_n_out              = cs_n_r;
    assign ee_mosi_out              = mosi_r;
    assign ee_busy_out              = busy_r;
    assign pin_level_bits_out       = mp_r;
    assign aux_conv_filter_sel_out  = aux_pwr_r[`PSG_FIL_POS +: 2];
    assign aux_conv_powerdown_out   = aux_pwr_r[`PSG_AUX_CONV_POWERDOWN_POS];
    assign ref_buffer_powerdown_out = aux_pwr_r[`PSG_REF_BUFFER_POWERDOWN_POS];
    assign ref_powerdown_out        = aux_pwr_r[`PSG_REF_POWERDOWN_POS];
    assign out_conv_powerdown_out   = {aux_pwr_r[0], aux_pwr_r[1], aux_pwr_r[2], aux_pwr_r[3]};
    assign aux_conv_on_out          = aux_en_r;
    assign osc_off_out              = osc_pd_r;
    assign out_conv_setup_out       = out_setup_r;

    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    a_param_pad_zero: assert property (cp_rvalid_out && $past(cp_addr_in) <= `PSG_PARAM7_ADDR
        && $past(cp_addr_in) >= `PSG_PARAM0_ADDR |-> cp_rdata_out[31:28] == 4'h0)
        else $error("saved parameter read with nonzero pad");
    a_core_refresh: assert property (sample_tick_in && !saved_param_host_write_in
        && state_r == PSG_EE_IDLE && !cp_wr_in |=> param_r[0] == $past(param_core_in[27:0]))
        else $error("parameter not refreshed on sample");
    a_host_mode_hold: assert property (saved_param_host_write_in && !cp_wr_in && !rx_take
        |=> $stable(param_r[7]))
        else $error("parameter changed in host write mode");
    a_save_start: assert property (trig_edge && state_r == PSG_EE_IDLE && !boot_pend_r
        |=> state_r == PSG_EE_WRITE && !ee_cs_n_out)
        else $error("trigger edge did not start save");
    a_boot_read: assert property (boot_go && boot_s_r |=> state_r == PSG_EE_READ)
        else $error("self-boot did not start restore");
    a_pin_rsvd_zero: assert property (cp_rvalid_out
        && $past(cp_addr_in) == `PSG_PIN_LEVEL_ADDR |-> cp_rdata_out[31:12] == 20'h00000)
        else $error("pin level register upper bits nonzero");
    a_aux_full_scale: assert property (aux_valid_in && aux_en_r && !aux_pwr_r[`PSG_AUX_CONV_POWERDOWN_POS]
        && !aux_data_host_write_in && aux_pwr_r[9:8] == 2'h0 && aux_code_in == 8'hff
        |=> aux_r[$past(aux_chan_in)] == 12'h800)
        else $error("full-scale code not unity");
    a_rsvd_read_zero: assert property (cp_rd_in && (cp_addr_in == `PSG_RSVD_A_ADDR
        || cp_addr_in == `PSG_RSVD_B_ADDR) |=> cp_rvalid_out && cp_rdata_out == 32'h0)
        else $error("reserved register read nonzero");
    a_pwr_mask: assert property ((aux_pwr_r & ~`PSG_AUX_PWR_MASK) == 16'h0000)
        else $error("unfilled power control bit set");
    a_frame_length: assert property ($rose(ee_cs_n_out)
        |-> $past(bit_cnt_r) == `PSG_EE_LAST_BIT)
        else $error("memory frame ended early");

    c_save_frame: cover property (state_r == PSG_EE_WRITE ##1 state_r == PSG_EE_IDLE);
    c_boot_restore: cover property (state_r == PSG_EE_READ ##1 state_r == PSG_EE_IDLE);
    c_aux_filtered: cover property (aux_valid_in && aux_pwr_r[9:8] != 2'h0 && aux_en_r);
    c_host_param: cover property (cp_wr_in && saved_param_host_write_in);
endmodule
